// ### design/pmp_pkg.sv
// package: constants, carriers and states for the mii port timing block
package pmp_pkg;

  // clock and bit-time bases, in picoseconds
  localparam int CLK_PS = 4000;
  localparam int BT100_PS = 10000;
  localparam int BT10_PS = 100000;
  localparam int PS_PER_NS = 1000;
  localparam int PS_PER_MS = 1000000000;
  localparam int CYC_PER_MS = PS_PER_MS / CLK_PS;
  localparam int TENTHS = 10;

  // least times round up to whole cycles, never below one
  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  // longest times round down, never below one
  function automatic int cyc_dn(input int ps);
    int c;
    c = ps / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_dn

  typedef logic [15:0] pmp_cnt_t;
  typedef logic [7:0] pmp_dly_t;
  localparam int DLY_AW = 8;

  // latency figures as printed, in bit times (tenths, ns or ms where marked)
  localparam int TXCRS_ON_FX_BT = 3;
  localparam int TXCRS_ON_10_BT = 2;
  localparam int TXCRS_OFF_FX_BT = 4;
  localparam int TXCRS_OFF_10_BT = 1;
  localparam int RXCRS_ON_FX_BT = 10;
  localparam int RXCRS_OFF_FX_BT = 14;
  localparam int RXCRS_ON_10_BT10 = 25;
  localparam int RXCRS_OFF_10_BT = 12;
  localparam int COL_ON_FX_BT = 10;
  localparam int COL_OFF_FX_BT = 14;
  localparam int COL_ON_10_BT = 3;
  localparam int COL_OFF_10_BT = 12;
  localparam int RXD_AFTER_CRS_FX_BT = 4;
  localparam int RX_LAT_10_BT10 = 66;
  localparam int RXD_HOLD_10_BT = 64;
  localparam int CRS_AFTER_DV_10_BT = 1;
  localparam int TX_LAT_FX_BT = 13;
  localparam int TX_LAT_10_NS = 280;
  localparam int HB_DELAY_MIN_NS = 650;
  localparam int HB_DELAY_MAX_NS = 1600;
  localparam int HB_PULSE_MIN_NS = 500;
  localparam int HB_PULSE_MAX_NS = 1500;
  localparam int JAB_MIN_MS = 20;
  localparam int JAB_MAX_MS = 150;
  localparam int UNJAB_MS = 750;

  // derived cycle counts
  localparam pmp_cnt_t TXCRS_ON_FX_CYC = pmp_cnt_t'(cyc_up(TXCRS_ON_FX_BT * BT100_PS));
  localparam pmp_cnt_t TXCRS_ON_10_CYC = pmp_cnt_t'(cyc_up(TXCRS_ON_10_BT * BT10_PS));
  localparam pmp_cnt_t TXCRS_OFF_FX_CYC = pmp_cnt_t'(cyc_up(TXCRS_OFF_FX_BT * BT100_PS));
  localparam pmp_cnt_t TXCRS_OFF_10_CYC = pmp_cnt_t'(cyc_up(TXCRS_OFF_10_BT * BT10_PS));
  localparam pmp_cnt_t RXCRS_ON_FX_CYC = pmp_cnt_t'(cyc_up(RXCRS_ON_FX_BT * BT100_PS));
  localparam pmp_cnt_t RXCRS_OFF_FX_CYC = pmp_cnt_t'(cyc_up(RXCRS_OFF_FX_BT * BT100_PS));
  localparam pmp_cnt_t RXCRS_ON_10_CYC =
    pmp_cnt_t'(cyc_up(RXCRS_ON_10_BT10 * (BT10_PS / TENTHS)));
  localparam pmp_cnt_t RXCRS_OFF_10_CYC = pmp_cnt_t'(cyc_up(RXCRS_OFF_10_BT * BT10_PS));
  localparam pmp_cnt_t COL_ON_FX_CYC = pmp_cnt_t'(cyc_up(COL_ON_FX_BT * BT100_PS));
  localparam pmp_cnt_t COL_OFF_FX_CYC = pmp_cnt_t'(cyc_up(COL_OFF_FX_BT * BT100_PS));
  localparam pmp_cnt_t COL_ON_10_CYC = pmp_cnt_t'(cyc_up(COL_ON_10_BT * BT10_PS));
  localparam pmp_cnt_t COL_OFF_10_CYC = pmp_cnt_t'(cyc_up(COL_OFF_10_BT * BT10_PS));
  localparam pmp_cnt_t RXD_HOLD_10_CYC = pmp_cnt_t'(cyc_up(RXD_HOLD_10_BT * BT10_PS));
  localparam pmp_cnt_t CRS_AFTER_DV_10_CYC = pmp_cnt_t'(cyc_up(CRS_AFTER_DV_10_BT * BT10_PS));
  localparam pmp_cnt_t HB_DELAY_CYC = pmp_cnt_t'(cyc_up(HB_DELAY_MIN_NS * PS_PER_NS));
  localparam pmp_cnt_t HB_DELAY_MAX_CYC = pmp_cnt_t'(cyc_dn(HB_DELAY_MAX_NS * PS_PER_NS));
  localparam pmp_cnt_t HB_PULSE_CYC = pmp_cnt_t'(cyc_up(HB_PULSE_MIN_NS * PS_PER_NS));
  localparam pmp_cnt_t HB_PULSE_MAX_CYC = pmp_cnt_t'(cyc_dn(HB_PULSE_MAX_NS * PS_PER_NS));

  // stream delays; the delay memory adds one cycle, so it is set one short
  localparam int RX_LAT_FX_CYC =
    cyc_up((RXCRS_ON_FX_BT + RXD_AFTER_CRS_FX_BT) * BT100_PS);
  localparam int RX_LAT_10_CYC = cyc_up(RX_LAT_10_BT10 * (BT10_PS / TENTHS));
  localparam int TX_LAT_FX_CYC = cyc_up(TX_LAT_FX_BT * BT100_PS);
  localparam int TX_LAT_10_CYC = cyc_up(TX_LAT_10_NS * PS_PER_NS);
  localparam pmp_dly_t RX_DLY_FX = pmp_dly_t'(RX_LAT_FX_CYC - 1);
  localparam pmp_dly_t RX_DLY_10 = pmp_dly_t'(RX_LAT_10_CYC - 1);
  localparam pmp_dly_t TX_DLY_FX = pmp_dly_t'(TX_LAT_FX_CYC - 1);
  localparam pmp_dly_t TX_DLY_10 = pmp_dly_t'(TX_LAT_10_CYC - 1);

  // jabber window: cut at the low end of the allowed range
  localparam int JAB_CYC_DEF = JAB_MIN_MS * CYC_PER_MS;
  localparam int UNJAB_CYC_DEF = UNJAB_MS * CYC_PER_MS;

  // carriers
  typedef struct packed {
    logic en;
    logic [3:0] data;
  } pmp_mii_tx_t;

  typedef struct packed {
    logic act;
    logic sfd;
    logic [3:0] data;
  } pmp_line_rx_t;

  typedef struct packed {
    logic dv;
    logic [3:0] data;
  } pmp_mii_rx_t;

  typedef struct packed {
    logic en;
    logic [3:0] data;
  } pmp_line_tx_t;

  typedef enum logic [1:0] {
    HB_IDLE,
    HB_WAIT,
    HB_PULSE
  } pmp_hb_t;

endpackage : pmp_pkg

// ### design/pmp_dly_mem.sv
// variable stream delay line: circular memory with registered read
`timescale 1ns/1ps
module pmp_dly_mem #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] wr_data,
  input wire pmp_pkg::pmp_dly_t dly,
  output logic [W-1:0] rd_data_ff
);
  localparam int DEPTH = 1 << pmp_pkg::DLY_AW;

  logic [W-1:0] mem_ff [DEPTH];
  pmp_pkg::pmp_dly_t wptr_ff;
  pmp_pkg::pmp_dly_t raddr;

  // entries reset so a fresh frame never reads stale activity
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_ff[i] <= '0;
      end else if (wptr_ff == pmp_pkg::pmp_dly_t'(i)) begin
        mem_ff[i] <= wr_data;
      end
    end
  end

  // write pointer advances every cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_ff <= '0;
    end else begin
      wptr_ff <= wptr_ff + pmp_pkg::pmp_dly_t'(1);
    end
  end

  assign raddr = wptr_ff - dly;

  // registered read: total latency is dly plus one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem_ff[raddr];
    end
  end

endmodule : pmp_dly_mem

// ### design/pmp_edge_dly.sv
// level follower with separate rise and fall latencies
`timescale 1ns/1ps
module pmp_edge_dly (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_lvl,
  input wire pmp_pkg::pmp_cnt_t rise_cyc,
  input wire pmp_pkg::pmp_cnt_t fall_cyc,
  output logic out_ff
);
  pmp_pkg::pmp_cnt_t cnt_ff;
  pmp_pkg::pmp_cnt_t target;

  assign target = out_ff ? fall_cyc : rise_cyc;

  // a glitch shorter than the latency restarts the count and never shows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      out_ff <= 1'b0;
    end else if (in_lvl == out_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff + pmp_pkg::pmp_cnt_t'(1) >= target) begin
      cnt_ff <= '0;
      out_ff <= in_lvl;
    end else begin
      cnt_ff <= cnt_ff + pmp_pkg::pmp_cnt_t'(1);
    end
  end

endmodule : pmp_edge_dly

// ### design/pmp_port.sv
// mii port timing: carrier sense, collision, data latency, heartbeat, jabber
`timescale 1ns/1ps
// Operation
// - fx receive: carrier on 10 bit times after J, off 14 after T
// - fx: collision on 10 bit times after J while colliding
// - fx: collision off 14 bit times after T
// - fx receive: data and valid start 4 bit times after carrier sense
// - transmit enable on: carrier sense after 3 (fx) or 2 (10t) bit times
// - transmit enable off: carrier drops after 4 (fx) or 1 (10t) bit times
// - line transmit starts 13 bit times (fx) or 280 ns (10t) after enable
// - 10t receive: line data reaches the mii after 6.6 bit times
// - 10t receive: carrier on 2.5 bit times after activity, off 12 after quiet
// - 10t: collision on 3 bit times after activity, off 12 after quiet
// - 10t receive: data held off 64 bit times, starts at delimiter
// - 10t frame end: carrier drops 1 bit time after data valid drops; carrier stays on until the later of that and 12 bit times after quiet
// - 10t heartbeat pulse starts 0.65 to 1.6 us after enable falls
// - 10t heartbeat pulse lasts 0.5 to 1.5 us
// - 10t jabber cuts long transmits, blocks 750 ms before resuming
module pmp_port #(
  parameter logic [31:0] JAB_CYC = 32'(pmp_pkg::JAB_CYC_DEF),
  parameter logic [31:0] UNJAB_CYC = 32'(pmp_pkg::UNJAB_CYC_DEF)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mii_clk,
  input wire pmp_pkg::pmp_mii_tx_t mii_tx,
  input wire logic mode_10,
  input wire pmp_pkg::pmp_line_rx_t line_receive_pair,
  output pmp_pkg::pmp_mii_rx_t mii_rx_ff,
  output logic crs_ff,
  output logic col_ff,
  output logic jabber_ff,
  output pmp_pkg::pmp_line_tx_t line_transmit_pair_ff
);

  // link side: hold each sampled nibble and flag it with a toggle
  pmp_pkg::pmp_mii_tx_t lnk_tx_ff;
  logic lnk_tgl_ff;

  always_ff @(posedge mii_clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk_tx_ff <= '0;
      lnk_tgl_ff <= 1'b0;
    end else begin
      lnk_tx_ff <= mii_tx;
      lnk_tgl_ff <= ~lnk_tgl_ff;
    end
  end

  // toggle crossing; the held word is stable for a whole link period
  logic tgl_m_ff, tgl_s_ff, tgl_d_ff;
  pmp_pkg::pmp_mii_tx_t tx_core_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_m_ff <= 1'b0;
      tgl_s_ff <= 1'b0;
      tgl_d_ff <= 1'b0;
    end else begin
      tgl_m_ff <= lnk_tgl_ff;
      tgl_s_ff <= tgl_m_ff;
      tgl_d_ff <= tgl_s_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_core_ff <= '0;
    end else if (tgl_s_ff != tgl_d_ff) begin
      tx_core_ff <= lnk_tx_ff;
    end
  end

  // pin synchronisers for line receive and the speed strap
  pmp_pkg::pmp_line_rx_t line_rx_m_ff, line_rx_s_ff;
  logic mode_m_ff, mode_s_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_rx_m_ff <= '0;
      line_rx_s_ff <= '0;
      mode_m_ff <= 1'b0;
      mode_s_ff <= 1'b0;
    end else begin
      line_rx_m_ff <= line_receive_pair;
      line_rx_s_ff <= line_rx_m_ff;
      mode_m_ff <= mode_10;
      mode_s_ff <= mode_m_ff;
    end
  end

  logic mode10, line_act, tx_en_c, tx_gate, col_cond;
  assign mode10 = mode_s_ff;
  assign line_act = line_rx_s_ff.act;
  assign tx_en_c = tx_core_ff.en;
  assign tx_gate = tx_en_c & ~jabber_ff;
  assign col_cond = tx_en_c & line_act;

  // jabber: count on-time, cut off, then wait out the unjab time
  logic [31:0] tx_on_cnt_ff, unjab_cnt_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_on_cnt_ff <= '0;
    end else if (!tx_en_c || !mode10 || jabber_ff) begin
      tx_on_cnt_ff <= '0;
    end else begin
      tx_on_cnt_ff <= tx_on_cnt_ff + 32'd1;
    end
  end

  // unjab only runs while the mac is quiet; a new enable restarts it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unjab_cnt_ff <= '0;
      jabber_ff <= 1'b0;
    end else if (!jabber_ff) begin
      unjab_cnt_ff <= '0;
      if (tx_en_c && mode10 && tx_on_cnt_ff == JAB_CYC - 32'd1) begin
        jabber_ff <= 1'b1;
      end
    end else if (tx_en_c) begin
      unjab_cnt_ff <= '0;
    end else if (unjab_cnt_ff == UNJAB_CYC - 32'd1) begin
      unjab_cnt_ff <= '0;
      jabber_ff <= 1'b0;
    end else begin
      unjab_cnt_ff <= unjab_cnt_ff + 32'd1;
    end
  end

  // latency targets picked by speed, typical figures used as targets
  pmp_pkg::pmp_cnt_t txc_on, txc_off, rxc_on, rxc_off, col_on, col_off;
  pmp_pkg::pmp_dly_t rx_dly, tx_dly;
  assign txc_on = mode10 ? pmp_pkg::TXCRS_ON_10_CYC : pmp_pkg::TXCRS_ON_FX_CYC;
  assign txc_off = mode10 ? pmp_pkg::TXCRS_OFF_10_CYC : pmp_pkg::TXCRS_OFF_FX_CYC;
  assign rxc_on = mode10 ? pmp_pkg::RXCRS_ON_10_CYC : pmp_pkg::RXCRS_ON_FX_CYC;
  assign rxc_off = mode10 ? pmp_pkg::RXCRS_OFF_10_CYC : pmp_pkg::RXCRS_OFF_FX_CYC;
  assign col_on = mode10 ? pmp_pkg::COL_ON_10_CYC : pmp_pkg::COL_ON_FX_CYC;
  assign col_off = mode10 ? pmp_pkg::COL_OFF_10_CYC : pmp_pkg::COL_OFF_FX_CYC;
  assign rx_dly = mode10 ? pmp_pkg::RX_DLY_10 : pmp_pkg::RX_DLY_FX;
  assign tx_dly = mode10 ? pmp_pkg::TX_DLY_10 : pmp_pkg::TX_DLY_FX;

  logic tx_crs_lvl, rx_crs_lvl, col_lvl;

  pmp_edge_dly u_txcrs (
    .clk(clk), .arst_n(arst_n), .in_lvl(tx_gate),
    .rise_cyc(txc_on), .fall_cyc(txc_off), .out_ff(tx_crs_lvl)
  );

  pmp_edge_dly u_rxcrs (
    .clk(clk), .arst_n(arst_n), .in_lvl(line_act),
    .rise_cyc(rxc_on), .fall_cyc(rxc_off), .out_ff(rx_crs_lvl)
  );

  pmp_edge_dly u_col (
    .clk(clk), .arst_n(arst_n), .in_lvl(col_cond),
    .rise_cyc(col_on), .fall_cyc(col_off), .out_ff(col_lvl)
  );

  // stream delays for receive and transmit data
  pmp_pkg::pmp_line_rx_t rx_dly_q;
  pmp_pkg::pmp_line_tx_t tx_in, tx_dly_q;
  assign tx_in = '{en: tx_gate, data: tx_core_ff.data};

  pmp_dly_mem #(.W($bits(pmp_pkg::pmp_line_rx_t))) u_rxmem (
    .clk(clk), .arst_n(arst_n), .wr_data(line_rx_s_ff), .dly(rx_dly), .rd_data_ff(rx_dly_q)
  );

  pmp_dly_mem #(.W($bits(pmp_pkg::pmp_line_tx_t))) u_txmem (
    .clk(clk), .arst_n(arst_n), .wr_data(tx_in), .dly(tx_dly), .rd_data_ff(tx_dly_q)
  );

  // 10t: age of carrier and delimiter seen, to gate data valid
  pmp_pkg::pmp_cnt_t crs_age_ff, dv_off_cnt_ff;
  logic sfd_seen_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crs_age_ff <= '0;
    end else if (!rx_crs_lvl) begin
      crs_age_ff <= '0;
    end else if (crs_age_ff < pmp_pkg::RXD_HOLD_10_CYC) begin
      crs_age_ff <= crs_age_ff + pmp_pkg::pmp_cnt_t'(1);
    end
  end

  // set wins over clear so a delimiter at frame edge is kept
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfd_seen_ff <= 1'b0;
    end else if (rx_dly_q.act && rx_dly_q.sfd) begin
      sfd_seen_ff <= 1'b1;
    end else if (!rx_dly_q.act) begin
      sfd_seen_ff <= 1'b0;
    end
  end

  logic nxt_dv;
  always_comb begin
    nxt_dv = rx_dly_q.act;
    if (mode10) begin
      nxt_dv = rx_dly_q.act && (sfd_seen_ff || rx_dly_q.sfd) &&
               (crs_age_ff >= pmp_pkg::RXD_HOLD_10_CYC);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mii_rx_ff <= '0;
    end else begin
      mii_rx_ff.dv <= nxt_dv;
      mii_rx_ff.data <= nxt_dv ? rx_dly_q.data : '0;
    end
  end

  // time since valid fell; in 10t the carrier outlives it by one bit time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dv_off_cnt_ff <= pmp_pkg::CRS_AFTER_DV_10_CYC;
    end else if (mii_rx_ff.dv) begin
      dv_off_cnt_ff <= '0;
    end else if (dv_off_cnt_ff < pmp_pkg::CRS_AFTER_DV_10_CYC) begin
      dv_off_cnt_ff <= dv_off_cnt_ff + pmp_pkg::pmp_cnt_t'(1);
    end
  end

  logic rx_crs;
  assign rx_crs = rx_crs_lvl ||
    (mode10 && dv_off_cnt_ff < pmp_pkg::CRS_AFTER_DV_10_CYC);

  // heartbeat after each 10t transmit that ends with jabber off and no new enable before the pulse
  pmp_pkg::pmp_hb_t hb_state_ff;
  pmp_pkg::pmp_cnt_t hb_cnt_ff;
  logic tx_en_d_ff, hb_pulse;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_en_d_ff <= 1'b0;
    end else begin
      tx_en_d_ff <= tx_en_c;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hb_state_ff <= pmp_pkg::HB_IDLE;
      hb_cnt_ff <= '0;
    end else begin
      case (hb_state_ff)
        pmp_pkg::HB_IDLE: begin
          hb_cnt_ff <= '0;
          if (tx_en_d_ff && !tx_en_c && mode10 && !jabber_ff) begin
            hb_state_ff <= pmp_pkg::HB_WAIT;
          end
        end
        pmp_pkg::HB_WAIT: begin
          if (tx_en_c) begin
            hb_state_ff <= pmp_pkg::HB_IDLE;
          end else if (hb_cnt_ff == pmp_pkg::HB_DELAY_CYC - pmp_pkg::pmp_cnt_t'(1)) begin
            hb_state_ff <= pmp_pkg::HB_PULSE;
            hb_cnt_ff <= '0;
          end else begin
            hb_cnt_ff <= hb_cnt_ff + pmp_pkg::pmp_cnt_t'(1);
          end
        end
        pmp_pkg::HB_PULSE: begin
          if (hb_cnt_ff == pmp_pkg::HB_PULSE_CYC - pmp_pkg::pmp_cnt_t'(1)) begin
            hb_state_ff <= pmp_pkg::HB_IDLE;
            hb_cnt_ff <= '0;
          end else begin
            hb_cnt_ff <= hb_cnt_ff + pmp_pkg::pmp_cnt_t'(1);
          end
        end
        default: begin
          hb_state_ff <= pmp_pkg::HB_IDLE;
          hb_cnt_ff <= '0;
        end
      endcase
    end
  end

  assign hb_pulse = (hb_state_ff == pmp_pkg::HB_PULSE);

  // mii outputs; crs and col are not aligned to any mac clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crs_ff <= 1'b0;
      col_ff <= 1'b0;
      line_transmit_pair_ff <= '0;
    end else begin
      crs_ff <= tx_crs_lvl | rx_crs;
      col_ff <= col_lvl | hb_pulse;
      line_transmit_pair_ff <= tx_dly_q;
    end
  end

  // checks
  localparam int A_RXC_FX_LO = int'(pmp_pkg::RXCRS_ON_FX_CYC) - 5;
  localparam int A_RXC_FX_HI = int'(pmp_pkg::RXCRS_ON_FX_CYC) - 1;
  localparam int A_RXC_10_LO = int'(pmp_pkg::RXCRS_ON_10_CYC) - 5;
  localparam int A_RXC_10_HI = int'(pmp_pkg::RXCRS_ON_10_CYC) - 1;
  localparam int A_COL_ON_LO = int'(pmp_pkg::COL_ON_FX_CYC) - 4;
  localparam int A_COL_ON_HI = int'(pmp_pkg::COL_ON_FX_CYC);
  localparam int A_COL_OFF_LO = int'(pmp_pkg::COL_OFF_FX_CYC) - 4;
  localparam int A_COL_OFF_HI = int'(pmp_pkg::COL_OFF_FX_CYC);
  localparam int A_TXC_ON_LO = int'(pmp_pkg::TXCRS_ON_FX_CYC) - 5;
  localparam int A_TXC_ON_HI = int'(pmp_pkg::TXCRS_ON_FX_CYC) - 1;
  localparam int A_TXC_OFF_LO = int'(pmp_pkg::TXCRS_OFF_FX_CYC) - 5;
  localparam int A_TXC_OFF_HI = int'(pmp_pkg::TXCRS_OFF_FX_CYC) - 1;
  localparam int A_TXL_LO = pmp_pkg::TX_LAT_FX_CYC - 2;
  localparam int A_TXL_HI = pmp_pkg::TX_LAT_FX_CYC + 4;
  localparam int A_HB_LO = int'(pmp_pkg::HB_DELAY_CYC) - 2;
  localparam int A_HB_HI = int'(pmp_pkg::HB_DELAY_MAX_CYC);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rx_crs_fx;
    (!mode10 && $rose(line_act)) ##1 (line_act && !mode10)[*4]
      |-> ##[A_RXC_FX_LO:A_RXC_FX_HI] rx_crs_lvl;
  endproperty
  a_rx_crs_fx: assert property (p_rx_crs_fx) else $error("fx carrier late");
  property p_col_on_fx;
    (!mode10 && $rose(col_cond)) ##1 (col_cond && !mode10)[*4]
      |-> ##[A_COL_ON_LO:A_COL_ON_HI] col_ff;
  endproperty
  a_col_on_fx: assert property (p_col_on_fx) else $error("fx collision late");
  property p_col_off_fx;
    (!mode10 && $fell(col_cond)) ##1 (!col_cond && !mode10)[*4]
      |-> ##[A_COL_OFF_LO:A_COL_OFF_HI] !col_ff;
  endproperty
  a_col_off_fx: assert property (p_col_off_fx) else $error("fx collision stuck");
  property p_dv_fx;
    ($rose(mii_rx_ff.dv) && !mode10) |-> $past(rx_crs_lvl, 8);
  endproperty
  a_dv_fx: assert property (p_dv_fx) else $error("fx data before carrier");
  property p_txcrs_on;
    (!mode10 && $rose(tx_gate)) ##1 (tx_gate && !mode10)[*4]
      |-> ##[A_TXC_ON_LO:A_TXC_ON_HI] tx_crs_lvl;
  endproperty
  a_txcrs_on: assert property (p_txcrs_on) else $error("tx carrier late");
  property p_txcrs_off;
    (!mode10 && $fell(tx_gate)) ##1 (!tx_gate && !mode10)[*4]
      |-> ##[A_TXC_OFF_LO:A_TXC_OFF_HI] !tx_crs_lvl;
  endproperty
  a_txcrs_off: assert property (p_txcrs_off) else $error("tx carrier stuck");
  property p_tx_line;
    (!mode10 && $rose(tx_gate)) |-> ##[A_TXL_LO:A_TXL_HI] line_transmit_pair_ff.en;
  endproperty
  a_tx_line: assert property (p_tx_line) else $error("line transmit late");
  property p_rx_crs_10;
    (mode10 && $rose(line_act)) ##1 (line_act && mode10)[*4]
      |-> ##[A_RXC_10_LO:A_RXC_10_HI] rx_crs_lvl;
  endproperty
  a_rx_crs_10: assert property (p_rx_crs_10) else $error("10t carrier late");
  property p_hold_10;
    ($rose(mii_rx_ff.dv) && mode10) |-> $past(crs_age_ff) >= pmp_pkg::RXD_HOLD_10_CYC;
  endproperty
  a_hold_10: assert property (p_hold_10) else $error("10t data too early");
  property p_crs_end_10;
    ($fell(crs_ff) && mode10) |-> !$past(mii_rx_ff.dv, 2);
  endproperty
  a_crs_end_10: assert property (p_crs_end_10) else $error("carrier fell before valid");
  property p_hb_delay;
    (mode10 && !jabber_ff && $fell(tx_en_c)) ##1 (!tx_en_c)[*2]
      |-> ##[A_HB_LO:A_HB_HI] hb_pulse;
  endproperty
  a_hb_delay: assert property (p_hb_delay) else $error("heartbeat late");
  property p_hb_width;
    $fell(hb_pulse) |-> $past(hb_cnt_ff) == pmp_pkg::HB_PULSE_CYC - pmp_pkg::pmp_cnt_t'(1);
  endproperty
  a_hb_width: assert property (p_hb_width) else $error("heartbeat width wrong");
  property p_jab;
    $rose(jabber_ff) |-> mode10 && $past(tx_on_cnt_ff) == JAB_CYC - 32'd1;
  endproperty
  a_jab: assert property (p_jab) else $error("jabber at wrong time");

  c_heartbeat: cover property ($fell(hb_pulse));
  c_jabber: cover property ($fell(jabber_ff));
  c_rx_10: cover property (mode10 && $rose(mii_rx_ff.dv));
  c_col_fx: cover property (!mode10 && $rose(col_ff));

endmodule : pmp_port

// ### tb/pmp_mac_model.sv
// mac-side model: transmit nibble stream out, carrier sense synchronised in
`timescale 1ns/1ps
module pmp_mac_model (
  input wire logic mii_clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic crs,
  output pmp_pkg::pmp_mii_tx_t mii_tx_ff,
  output logic crs_sync_ff
);
  logic crs_meta_ff;
  // idle data flips each cycle so a stale nibble never looks valid
  always_ff @(posedge mii_clk or negedge arst_n) begin
    if (!arst_n) begin
      mii_tx_ff <= '0;
    end else begin
      mii_tx_ff.en <= go;
      mii_tx_ff.data <= go ? mii_tx_ff.data + 4'h1 : ~mii_tx_ff.data;
    end
  end
  // carrier comes from another clock, two flops before use
  always_ff @(posedge mii_clk or negedge arst_n) begin
    if (!arst_n) begin
      crs_meta_ff <= 1'b0;
      crs_sync_ff <= 1'b0;
    end else begin
      crs_meta_ff <= crs;
      crs_sync_ff <= crs_meta_ff;
    end
  end
endmodule : pmp_mac_model

// ### tb/testbench.sv
// self-checking bench for the mii port timing block
`timescale 1ns/1ps
module testbench;
  localparam int JAB = 200;
  localparam int UNJAB = 300;
  logic clk = 1'b0;
  logic mii_clk = 1'b0;
  logic arst_n = 1'b0;
  logic go = 1'b0;
  logic mode_10 = 1'b0;
  pmp_pkg::pmp_line_rx_t lrx = '0;
  pmp_pkg::pmp_mii_tx_t mii_tx;
  pmp_pkg::pmp_mii_rx_t mii_rx;
  pmp_pkg::pmp_line_tx_t ltx;
  logic crs, col, jab_on, crs_mac;
  int failures = 0;
  int checked = 0;
  // core and link clocks, unrelated in phase
  always #2 clk = ~clk;
  always #15 mii_clk = ~mii_clk;
  pmp_mac_model i_pmp_mac_model (.mii_clk(mii_clk), .arst_n(arst_n), .go(go), .crs(crs),
    .mii_tx_ff(mii_tx), .crs_sync_ff(crs_mac));
  pmp_port #(.JAB_CYC(32'(JAB)), .UNJAB_CYC(32'(UNJAB))) i_pmp_port (.clk(clk),
    .arst_n(arst_n), .mii_clk(mii_clk), .mii_tx(mii_tx), .mode_10(mode_10),
    .line_receive_pair(lrx), .mii_rx_ff(mii_rx), .crs_ff(crs), .col_ff(col),
    .jabber_ff(jab_on), .line_transmit_pair_ff(ltx));
  function automatic logic sel(input int s);
    case (s)
      0: return crs;
      1: return col;
      2: return mii_rx.dv;
      3: return ltx.en;
      default: return jab_on;
    endcase
  endfunction : sel
  task automatic chk(input logic [31:0] got, input int lo, input int hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk
  // bounded wait, sampled 1 ns after the edge so outputs have settled
  task automatic wait_sig(input int s, input logic v, output int n);
    n = 0;
    while (sel(s) !== v && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_sig
  // go passes two link registers (mac, port) plus the crossing, hence the margins
  task automatic tx_lat(input logic m);
    int n, n2;
    @(posedge clk);
    mode_10 <= m;
    repeat (20) @(posedge clk);
    go <= 1'b1;
    wait_sig(0, 1'b1, n);
    chk(n, m ? pmp_pkg::TXCRS_ON_10_CYC : pmp_pkg::TXCRS_ON_FX_CYC, n + 0);
    chk(n, 0, (m ? pmp_pkg::TXCRS_ON_10_CYC : pmp_pkg::TXCRS_ON_FX_CYC) + 22);
    wait_sig(3, 1'b1, n2);
    chk(n + n2, m ? pmp_pkg::TX_LAT_10_CYC : pmp_pkg::TX_LAT_FX_CYC, n + n2 + 0);
    chk(n + n2, 0, (m ? pmp_pkg::TX_LAT_10_CYC : pmp_pkg::TX_LAT_FX_CYC) + 24);
    chk(crs_mac, 1, 1);
    @(posedge clk);
    go <= 1'b0;
    wait_sig(0, 1'b0, n);
    chk(n, m ? pmp_pkg::TXCRS_OFF_10_CYC : pmp_pkg::TXCRS_OFF_FX_CYC, 60);
    if (m) begin
      wait_sig(1, 1'b1, n2);
      chk(n + n2, pmp_pkg::HB_DELAY_CYC, pmp_pkg::HB_DELAY_MAX_CYC);
      wait_sig(1, 1'b0, n);
      chk(n, pmp_pkg::HB_PULSE_CYC, pmp_pkg::HB_PULSE_MAX_CYC);
    end
    repeat (100) @(posedge clk);
    $display("test tx_lat mode %0d done", m);
  endtask : tx_lat
  task automatic fx_rx(input logic coll);
    int n;
    @(posedge clk);
    mode_10 <= 1'b0;
    go <= coll;
    repeat (60) @(posedge clk);
    lrx <= '{act: 1'b1, sfd: 1'b0, data: 4'h5};
    wait_sig(coll ? 1 : 0, 1'b1, n);
    chk(n, pmp_pkg::RXCRS_ON_FX_CYC, pmp_pkg::RXCRS_ON_FX_CYC + 7);
    if (!coll) begin
      wait_sig(2, 1'b1, n);
      chk(n, 8, 14);
      chk(mii_rx.data, 5, 5);
    end
    @(posedge clk);
    lrx <= '0;
    wait_sig(coll ? 1 : 0, 1'b0, n);
    chk(n, pmp_pkg::COL_OFF_FX_CYC, pmp_pkg::COL_OFF_FX_CYC + 7);
    go <= 1'b0;
    repeat (100) @(posedge clk);
    $display("test fx_rx coll %0d done", coll);
  endtask : fx_rx
  task automatic rx10();
    int n;
    @(posedge clk);
    mode_10 <= 1'b1;
    repeat (20) @(posedge clk);
    lrx <= '{act: 1'b1, sfd: 1'b0, data: 4'ha};
    wait_sig(0, 1'b1, n);
    chk(n, pmp_pkg::RXCRS_ON_10_CYC, pmp_pkg::RXCRS_ON_10_CYC + 6);
    repeat (1700) @(posedge clk);
    lrx.sfd <= 1'b1;
    wait_sig(2, 1'b1, n);
    chk(n, pmp_pkg::RX_LAT_10_CYC, pmp_pkg::RX_LAT_10_CYC + 6);
    chk(mii_rx.data, 10, 10);
    @(posedge clk);
    lrx <= '0;
    wait_sig(2, 1'b0, n);
    wait_sig(0, 1'b0, n);
    chk(n, pmp_pkg::CRS_AFTER_DV_10_CYC, pmp_pkg::RXCRS_OFF_10_CYC);
    $display("test rx10 done");
  endtask : rx10
  // long transmit in 10t: cut, blocked, then released after quiet
  task automatic jab();
    int n;
    @(posedge clk);
    mode_10 <= 1'b1;
    repeat (20) @(posedge clk);
    go <= 1'b1;
    wait_sig(4, 1'b1, n);
    chk(n, JAB, JAB + 24);
    repeat (100) @(posedge clk);
    chk(ltx.en, 0, 0);
    go <= 1'b0;
    wait_sig(4, 1'b0, n);
    chk(n, UNJAB, UNJAB + 24);
    $display("test jab done");
  endtask : jab
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    tx_lat(1'b0);
    tx_lat(1'b1);
    fx_rx(1'b0);
    fx_rx(1'b1);
    rx10();
    jab();
    report_and_stop();
  end
  // hang guard, well past the few thousand cycles the tests need
  initial begin
    #60000;
    failures++;
    report_and_stop();
  end
endmodule : testbench
